// ### verilog/bpsl_pkg.sv
// What this block does
// - Auto LED: green, blue IDE, red reset, yellow standby.
// - Auto LED white near thermal limit.
// - Auto LED cyan 10M, magenta 100M, blink activity.
// - Jumper fitted at power-up forces red in automatic display.
// - LED field zero selects automatic display.
// - Manual codes 0x08 off through 0x0F white.
// - Configuration bit can keep LED dark.
// - Reset status reads one per asserted source, except reserved bit D2.
// - Writing one clears a reset status bit.
// - Reset status bit assignment D7 to D0.
// - Higher priority source also sets lower ones.
// - Non-reset button leaves utility bit zero.
// - Ring indicator of either port wakes.
// - Digital I/O interrupts wake from any state.
// - Power-management event input wakes the system.
// - Real-time-clock alarm powers system on daily.
// - Open-drain power-on request, released when off.
// - Supply inputs monitored to make power-good.
`default_nettype none
package bpsl_pkg;

   // Legacy I/O port locations.
   localparam logic [15:0] LED_CTRL_ADDR  = 16'h0456;
   localparam logic [15:0] RST_CAUSE_ADDR = 16'h0457;

   // Reset values.
   localparam logic [7:0]  LED_CTRL_RESET  = 8'h00;
   localparam logic [7:0]  RST_CAUSE_RESET = 8'h00;

   // Reset status bit positions.
   localparam int RC_MAIN    = 7;
   localparam int RC_CORE    = 6;
   localparam int RC_NONSTBY = 5;
   localparam int RC_MEM     = 4;
   localparam int RC_STBY    = 3;
   localparam int RC_RSVD    = 2;
   localparam int RC_PCI     = 1;
   localparam int RC_UTIL    = 0;

   // Bits implied by a source of each priority level.
   localparam logic [7:0]  RC_BY_STBY  = 8'hFA;
   localparam logic [7:0]  RC_BY_MAIN  = 8'hF2;
   // Level three implies only the PCI bit; its peers share the level and stay apart.
   localparam logic [7:0]  RC_BY_LVL3  = 8'h02;
   localparam logic [7:0]  RC_DIRECT   = 8'hFA;

   // LED register layout: low nibble is the LED field, bit 4 reads zero.
   localparam int          LED_MANUAL_BIT = 3;
   localparam logic [7:0]  LED_WR_MASK    = 8'hEF;
   localparam logic [3:0]  LED_CODE_AUTO  = 4'h0;

   // Colours as {red, green, blue}.
   typedef logic [2:0] bpsl_rgb_t;
   localparam bpsl_rgb_t COL_OFF     = 3'h0;
   localparam bpsl_rgb_t COL_BLUE    = 3'h1;
   localparam bpsl_rgb_t COL_GREEN   = 3'h2;
   localparam bpsl_rgb_t COL_CYAN    = 3'h3;
   localparam bpsl_rgb_t COL_RED     = 3'h4;
   localparam bpsl_rgb_t COL_MAGENTA = 3'h5;
   localparam bpsl_rgb_t COL_YELLOW  = 3'h6;
   localparam bpsl_rgb_t COL_WHITE   = 3'h7;

   // Timing.
   localparam int unsigned CLK_PERIOD_NS  = 25;
   localparam int unsigned BLINK_HALF_MS  = 100;
   localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
   localparam logic [1:0]  JMP_SETTLE_CYC = 2'h3;

   // Main rail sequencing.
   typedef enum logic [1:0] {PWR_OFF, PWR_START, PWR_ON} bpsl_pwr_e;

endpackage
`default_nettype wire

// ### verilog/bpsl_led_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bpsl_led_if;
   logic       led_en;
   logic       jumper_red;
   logic       in_reset;
   logic       standby;
   logic       thermal;
   logic       ide_act;
   logic       eth_link;
   logic       eth_100;
   logic       eth_act;
   logic [3:0] code;

   modport ctl (output led_en, jumper_red, in_reset, standby, thermal, ide_act, eth_link, eth_100, eth_act, code);
   modport led (input  led_en, jumper_red, in_reset, standby, thermal, ide_act, eth_link, eth_100, eth_act, code);
endinterface
`default_nettype wire

// ### verilog/bpsl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bpsl_sync
   import bpsl_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset.
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   // Asynchronous levels in, synchronised levels out.
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_q;

   // Two stages; only the second stage is visible to other logic.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_q <= '0;
         q_o    <= '0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end

endmodule
`default_nettype wire

// ### verilog/bpsl_led.sv
`timescale 1ns/1ps
`default_nettype none
module bpsl_led
   import bpsl_pkg::*;
#(
   parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
   // Clock and reset.
   input  wire logic   sys_clk_i,
   input  wire logic   sys_rst_i,
   // Status and control.
   bpsl_led_if.led     st,
   // LED drive.
   output bpsl_rgb_t   rgb_o
);

   localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYC - 1);

   logic [31:0] blink_cnt_q;
   logic        blink_off_q;
   bpsl_rgb_t   auto_col;

   // Free-running blink phase; activity only darkens the off half.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         blink_cnt_q <= 32'h0000_0000;
         blink_off_q <= 1'b0;
      end else if (blink_cnt_q >= BLINK_LAST) begin
         blink_cnt_q <= 32'h0000_0000;
         blink_off_q <= ~blink_off_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
      end
   end

   // Automatic status, most urgent condition first.
   always_comb begin
      if (st.jumper_red || st.in_reset) begin
         auto_col = COL_RED;
      end else if (st.standby) begin
         auto_col = COL_YELLOW;
      end else if (st.thermal) begin
         auto_col = COL_WHITE;
      end else if (st.ide_act) begin
         auto_col = COL_BLUE;
      end else if (st.eth_link) begin
         auto_col = (st.eth_act && blink_off_q) ? COL_OFF : (st.eth_100 ? COL_MAGENTA : COL_CYAN);
      end else begin
         auto_col = COL_GREEN;
      end
   end

   // Codes with the manual bit clear show automatic status.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rgb_o <= COL_OFF;
      end else if (!st.led_en) begin
         rgb_o <= COL_OFF;
      end else if (st.code[LED_MANUAL_BIT]) begin
         rgb_o <= st.code[2:0];
      end else begin
         rgb_o <= auto_col;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   AST_LED_DARK: assert property (!st.led_en |=> rgb_o == COL_OFF)
      else $error("LED lit while disabled.");
   AST_LED_MANUAL: assert property (st.led_en && st.code[LED_MANUAL_BIT] |=> rgb_o == $past(st.code[2:0]))
      else $error("Manual LED code not shown.");
   AST_LED_JUMPER: assert property (st.led_en && st.code == LED_CODE_AUTO && st.jumper_red |=> rgb_o == COL_RED)
      else $error("Jumper red not shown.");
   AST_LED_THERMAL: assert property (st.led_en && st.code == LED_CODE_AUTO && !st.jumper_red && !st.in_reset
                                     && !st.standby && st.thermal |=> rgb_o == COL_WHITE)
      else $error("Thermal white not shown.");

endmodule
`default_nettype wire

// ### verilog/board_power_status_logic.sv
`timescale 1ns/1ps
`default_nettype none
module board_power_status_logic
   import bpsl_pkg::*;
#(
   parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
   // Clock and reset.
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   // Legacy I/O port access from the host bridge.
   input  wire logic [15:0] io_addr_i,
   input  wire logic        io_wr_i,
   input  wire logic        io_rd_i,
   input  wire logic [7:0]  io_wdata_i,
   output logic      [7:0]  io_rdata_o,
   // Setup configuration levels.
   input  wire logic        cfg_led_en_i,
   input  wire logic        cfg_ring_wake_en_i,
   input  wire logic        cfg_dio_wake_en_i,
   input  wire logic        cfg_pme_wake_en_i,
   input  wire logic        cfg_alarm_wake_en_i,
   input  wire logic        cfg_util_is_reset_i,
   // Wake sources.
   input  wire logic [1:0]  ring_i,
   input  wire logic [2:0]  dio_irq_i,
   input  wire logic [2:0]  pme_n_i,
   input  wire logic        rtc_alarm_i,
   // Power supply.
   input  wire logic        sleep_req_i,
   input  wire logic [3:0]  supply_ok_i,
   output logic             psu_on_n_o,
   output logic             psu_on_oe_n_o,
   output logic             power_good_o,
   output logic             wake_event_o,
   // Reset sources, one per status bit.
   input  wire logic [7:0]  rst_src_i,
   // Board status for the LED.
   input  wire logic        board_rst_i,
   input  wire logic        default_config_jumper_i,
   input  wire logic        ide_act_i,
   input  wire logic        eth_link_i,
   input  wire logic        eth_100_i,
   input  wire logic        eth_act_i,
   input  wire logic        thermal_warn_i,
   // LED drive as {red, green, blue}.
   output logic      [2:0]  led_rgb_o
);

   localparam int SYNC_W = 29;

   logic [SYNC_W-1:0] async_bus;
   logic [SYNC_W-1:0] sync_bus;
   logic [1:0]        ring_s;
   logic [2:0]        dio_s;
   logic [2:0]        pme_n_s;
   logic              alarm_s;
   logic              sleep_s;
   logic [3:0]        supply_s;
   logic [7:0]        src_s;
   logic              board_rst_s;
   logic              jumper_s;
   logic              ide_s;
   logic              link_s;
   logic              spd_s;
   logic              act_s;
   logic              therm_s;

   // Every wake, supply, reset-source and board status pin level is synchronised once, in one block.
   assign async_bus = {ring_i, dio_irq_i, pme_n_i, rtc_alarm_i, sleep_req_i, supply_ok_i, rst_src_i,
                       board_rst_i, default_config_jumper_i, ide_act_i, eth_link_i, eth_100_i,
                       eth_act_i, thermal_warn_i};

   bpsl_sync #(
      .W (SYNC_W)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       (async_bus),
      .q_o       (sync_bus)
   );

   assign {ring_s, dio_s, pme_n_s, alarm_s, sleep_s, supply_s, src_s,
           board_rst_s, jumper_s, ide_s, link_s, spd_s, act_s, therm_s} = sync_bus;

   // Edge detection on the synchronised wake and button inputs.
   logic [1:0] ring_prev_q;
   logic [2:0] dio_prev_q;
   logic [2:0] pme_n_prev_q;
   logic       alarm_prev_q;
   logic       util_prev_q;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ring_prev_q  <= 2'h0;
         dio_prev_q   <= 3'h0;
         pme_n_prev_q <= 3'h0;
         alarm_prev_q <= 1'b0;
         util_prev_q  <= 1'b0;
      end else begin
         ring_prev_q  <= ring_s;
         dio_prev_q   <= dio_s;
         pme_n_prev_q <= pme_n_s;
         alarm_prev_q <= alarm_s;
         util_prev_q  <= src_s[RC_UTIL];
      end
   end

   logic ring_wake;
   logic dio_wake;
   logic pme_wake;
   logic alarm_wake;
   logic any_wake;
   logic util_press;

   // Each enabled source wakes on its asserting edge, so a held level does not re-wake after sleep.
   assign ring_wake  = cfg_ring_wake_en_i && |(ring_s & ~ring_prev_q);
   assign dio_wake   = cfg_dio_wake_en_i && |(dio_s & ~dio_prev_q);
   assign pme_wake   = cfg_pme_wake_en_i && |(pme_n_prev_q & ~pme_n_s);
   assign alarm_wake = cfg_alarm_wake_en_i && alarm_s && !alarm_prev_q;
   assign any_wake   = ring_wake || dio_wake || pme_wake || alarm_wake;
   assign util_press = src_s[RC_UTIL] && !util_prev_q;

   // Main rail sequencing; this logic lives on standby power and runs through every sleep state.
   bpsl_pwr_e pwr_q;
   bpsl_pwr_e pwr_d;
   logic      all_ok;

   assign all_ok = &supply_s;

   always_comb begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         PWR_OFF: begin
            if (any_wake) begin
               pwr_d = PWR_START;
            end
         end
         PWR_START: begin
            if (all_ok) begin
               pwr_d = PWR_ON;
            end
         end
         PWR_ON: begin
            if (sleep_s || !all_ok) begin
               pwr_d = PWR_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pwr_q <= PWR_OFF;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   // Open-drain request: the data is always low, only the enable moves.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         psu_on_n_o    <= 1'b0;
         psu_on_oe_n_o <= 1'b1;
      end else begin
         psu_on_n_o    <= 1'b0;
         psu_on_oe_n_o <= (pwr_d == PWR_OFF);
      end
   end

   // Power-good follows the monitored rails only once the sequence has reached on.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         power_good_o <= 1'b0;
         wake_event_o <= 1'b0;
      end else begin
         power_good_o <= (pwr_d == PWR_ON);
         wake_event_o <= (pwr_q == PWR_OFF) && any_wake;
      end
   end

   // Register decode.
   logic led_wr;
   logic rc_wr;

   assign led_wr = io_wr_i && (io_addr_i == LED_CTRL_ADDR);
   assign rc_wr  = io_wr_i && (io_addr_i == RST_CAUSE_ADDR);

   // LED control register; software is trusted to keep the upper bits as read.
   logic [7:0] led_ctrl_q;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         led_ctrl_q <= LED_CTRL_RESET;
      end else if (led_wr) begin
         led_ctrl_q <= io_wdata_i & LED_WR_MASK;
      end
   end

   // Reset cause capture with priority fan-out.
   logic [7:0] rc_q;
   logic [7:0] rc_set;
   logic [7:0] rc_clr;

   always_comb begin
      rc_set = src_s & RC_DIRECT;
      if (src_s[RC_STBY]) begin
         rc_set = rc_set | RC_BY_STBY;
      end
      if (src_s[RC_MAIN]) begin
         rc_set = rc_set | RC_BY_MAIN;
      end
      if (src_s[RC_CORE] || src_s[RC_NONSTBY] || src_s[RC_MEM]) begin
         rc_set = rc_set | RC_BY_LVL3;
      end
      rc_set[RC_UTIL] = util_press && cfg_util_is_reset_i;
      rc_clr = rc_wr ? io_wdata_i : 8'h00;
      rc_clr[RC_UTIL] = rc_clr[RC_UTIL] || (util_press && !cfg_util_is_reset_i);
   end

   // Reset, a written one or a non-reset utility press clears bits; a new event beats a clear in the same cycle.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rc_q <= RST_CAUSE_RESET;
      end else begin
         rc_q <= (rc_q & ~rc_clr) | rc_set;
      end
   end

   // Read data, one cycle after the strobe; unmapped ports read zero.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         io_rdata_o <= 8'h00;
      end else if (io_rd_i) begin
         if (io_addr_i == LED_CTRL_ADDR) begin
            io_rdata_o <= led_ctrl_q;
         end else if (io_addr_i == RST_CAUSE_ADDR) begin
            io_rdata_o <= rc_q;
         end else begin
            io_rdata_o <= 8'h00;
         end
      end
   end

   // Jumper is sampled once, after the synchroniser has settled following power-up.
   logic [1:0] settle_q;
   logic       jumper_red_q;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         settle_q     <= 2'h0;
         jumper_red_q <= 1'b0;
      end else if (settle_q != JMP_SETTLE_CYC) begin
         settle_q <= settle_q + 2'h1;
         if (settle_q == JMP_SETTLE_CYC - 2'h1) begin
            jumper_red_q <= jumper_s;
         end
      end
   end

   // LED status bundle.
   bpsl_led_if led_bus ();

   assign led_bus.led_en     = cfg_led_en_i;
   assign led_bus.jumper_red = jumper_red_q;
   assign led_bus.in_reset   = board_rst_s || (pwr_q == PWR_START);
   assign led_bus.standby    = (pwr_q == PWR_OFF);
   assign led_bus.thermal    = therm_s;
   assign led_bus.ide_act    = ide_s;
   assign led_bus.eth_link   = link_s;
   assign led_bus.eth_100    = spd_s;
   assign led_bus.eth_act    = act_s;
   assign led_bus.code       = led_ctrl_q[3:0];

   bpsl_led #(
      .BLINK_CYC (BLINK_CYC)
   ) u_led (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .st        (led_bus),
      .rgb_o     (led_rgb_o)
   );

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_wake_in_off;
      (pwr_q == PWR_OFF) && any_wake;
   endsequence

   sequence s_rails_requested;
      wake_event_o && !psu_on_oe_n_o && (pwr_q == PWR_START);
   endsequence

   AST_WAKE_SEQ: assert property (s_wake_in_off |=> s_rails_requested)
      else $error("Wake did not request main rails.");
   AST_PSON_RELEASE: assert property (pwr_q == PWR_OFF |-> psu_on_oe_n_o && psu_on_n_o == 1'b0)
      else $error("Power request driven while off.");
   AST_PGOOD: assert property (power_good_o |-> pwr_q == PWR_ON && $past(all_ok))
      else $error("Power-good without good rails.");
   AST_RC_STICKY: assert property (rc_q[RC_MAIN] && !(rc_wr && io_wdata_i[RC_MAIN]) |=> rc_q[RC_MAIN])
      else $error("Reset cause bit lost without clear.");
   AST_RC_W1C: assert property (rc_wr && io_wdata_i[RC_PCI] && rc_set[RC_PCI] == 1'b0 |=> !rc_q[RC_PCI])
      else $error("Write one did not clear.");
   AST_RC_KEEP0: assert property (rc_wr && !io_wdata_i[RC_MEM] && rc_q[RC_MEM] |=> rc_q[RC_MEM])
      else $error("Write zero changed a bit.");
   AST_RC_STBY_PRIO: assert property (src_s[RC_STBY] |=> (rc_q & RC_BY_STBY) == RC_BY_STBY)
      else $error("Standby source did not set lower priorities.");
   AST_RC_MAIN_PRIO: assert property (src_s[RC_MAIN] |=> (rc_q & RC_BY_MAIN) == RC_BY_MAIN && !rc_q[RC_RSVD])
      else $error("Main source did not set lower priorities.");
   AST_RC_UTIL: assert property (util_press && !cfg_util_is_reset_i |=> !rc_q[RC_UTIL])
      else $error("Utility bit set by non-reset button.");
   AST_RC_READ: assert property (io_rd_i && io_addr_i == RST_CAUSE_ADDR |=> io_rdata_o == $past(rc_q))
      else $error("Reset status read mismatch.");

endmodule
`default_nettype wire

// ### dv/bpsl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); end end
module testbench;
   import bpsl_pkg::*;

   // Design inputs, all given a value at time zero.
   logic        sys_clk_i = 1'b0, sys_rst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0;
   logic [15:0] io_addr_i = 16'h0000;
   logic [7:0]  io_wdata_i = 8'h00, rst_src_i = 8'h00;
   logic        cfg_led_en_i = 1'b1, cfg_ring_wake_en_i = 1'b0, cfg_dio_wake_en_i = 1'b0;
   logic        cfg_pme_wake_en_i = 1'b0, cfg_alarm_wake_en_i = 1'b0, cfg_util_is_reset_i = 1'b1;
   logic [1:0]  ring_i = 2'h0;
   logic [2:0]  dio_irq_i = 3'h0, pme_n_i = 3'h7;
   logic        rtc_alarm_i = 1'b0, sleep_req_i = 1'b0, board_rst_i = 1'b0;
   logic [3:0]  supply_ok_i = 4'h0;
   logic        default_config_jumper_i = 1'b0, ide_act_i = 1'b0, eth_link_i = 1'b0;
   logic        eth_100_i = 1'b0, eth_act_i = 1'b0, thermal_warn_i = 1'b0;
   // Design outputs.
   logic [7:0]  io_rdata_o;
   logic        psu_on_n_o, psu_on_oe_n_o, power_good_o, wake_event_o;
   logic [2:0]  led_rgb_o;
   // Bench bookkeeping.
   int          err_count = 0;
   int          n_tests = 0;
   logic [7:0]  rd;
   logic        seen;

   // A short blink period keeps the activity check within a few dozen cycles.
   board_power_status_logic #(.BLINK_CYC(4)) i_dut (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
      .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .cfg_led_en_i(cfg_led_en_i),
      .cfg_ring_wake_en_i(cfg_ring_wake_en_i), .cfg_dio_wake_en_i(cfg_dio_wake_en_i),
      .cfg_pme_wake_en_i(cfg_pme_wake_en_i), .cfg_alarm_wake_en_i(cfg_alarm_wake_en_i),
      .cfg_util_is_reset_i(cfg_util_is_reset_i), .ring_i(ring_i), .dio_irq_i(dio_irq_i), .pme_n_i(pme_n_i),
      .rtc_alarm_i(rtc_alarm_i), .sleep_req_i(sleep_req_i), .supply_ok_i(supply_ok_i),
      .psu_on_n_o(psu_on_n_o), .psu_on_oe_n_o(psu_on_oe_n_o), .power_good_o(power_good_o),
      .wake_event_o(wake_event_o), .rst_src_i(rst_src_i), .board_rst_i(board_rst_i),
      .default_config_jumper_i(default_config_jumper_i), .ide_act_i(ide_act_i), .eth_link_i(eth_link_i),
      .eth_100_i(eth_100_i), .eth_act_i(eth_act_i), .thermal_warn_i(thermal_warn_i), .led_rgb_o(led_rgb_o));

   // Clock of 25 ns period.
   always #12.5 sys_clk_i = ~sys_clk_i;

   // Lets n edges pass, then steps past the edge so outputs are settled.
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   // One write cycle; the strobe is lowered at the edge that takes it.
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      io_addr_i <= a;
      io_wdata_i <= d;
      io_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      io_wr_i <= 1'b0;
   endtask

   // One read cycle; data is valid just after the taking edge.
   task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      io_addr_i <= a;
      io_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      io_rd_i <= 1'b0;
      #1 d = io_rdata_o;
   endtask

   // Raises one reset source for a few cycles and lets the synchroniser catch up.
   task automatic src_pulse(input logic [7:0] s);
      @(posedge sys_clk_i);
      rst_src_i <= s;
      settle(5);
      @(posedge sys_clk_i);
      rst_src_i <= 8'h00;
      settle(5);
   endtask

   // Fires wake source k with all enables at en, and watches for the pulse.
   task automatic wake(input int k, input logic en, output logic got);
      @(posedge sys_clk_i);
      {cfg_ring_wake_en_i, cfg_dio_wake_en_i, cfg_pme_wake_en_i, cfg_alarm_wake_en_i} <= {4{en}};
      case (k)
         0: ring_i <= 2'b10;
         1: dio_irq_i <= 3'b100;
         2: pme_n_i <= 3'b101;
         default: rtc_alarm_i <= 1'b1;
      endcase
      got = 1'b0;
      for (int i = 0; i < 12; i++) begin
         settle(1);
         if (wake_event_o === 1'b1) got = 1'b1;
      end
      @(posedge sys_clk_i);
      ring_i <= 2'b00;
      dio_irq_i <= 3'b000;
      pme_n_i <= 3'b111;
      rtc_alarm_i <= 1'b0;
      settle(4);
   endtask

   // Sets the automatic-mode status inputs and checks the colour shown.
   task automatic led_case(input logic [4:0] s, input bpsl_rgb_t e);
      @(posedge sys_clk_i);
      {board_rst_i, thermal_warn_i, ide_act_i, eth_link_i, eth_100_i} <= s;
      settle(6);
      `CHK(led_rgb_o, e)
   endtask

   // Reset cause recording, priority fan-out and write-one-to-clear.
   task automatic test_cause();
      logic [7:0] src [7] = '{8'h08, 8'h80, 8'h40, 8'h20, 8'h10, 8'h02, 8'h04};
      logic [7:0] exp [7] = '{8'hFA, 8'hF2, 8'h42, 8'h22, 8'h12, 8'h02, 8'h00};
      for (int i = 0; i < 7; i++) begin
         src_pulse(src[i]);
         io_rd(RST_CAUSE_ADDR, rd);
         `CHK(rd, exp[i])
         io_wr(RST_CAUSE_ADDR, 8'h0F);
         io_rd(RST_CAUSE_ADDR, rd);
         `CHK(rd, exp[i] & 8'hF0)
         io_wr(RST_CAUSE_ADDR, 8'hFF);
         io_rd(RST_CAUSE_ADDR, rd);
         `CHK(rd, 8'h00)
      end
      src_pulse(8'h01);
      io_rd(RST_CAUSE_ADDR, rd);
      `CHK(rd, 8'h01)
      @(posedge sys_clk_i);
      cfg_util_is_reset_i <= 1'b0;
      src_pulse(8'h01);
      io_rd(RST_CAUSE_ADDR, rd);
      `CHK(rd, 8'h00)
   endtask

   // Each wake source ignored while disabled, then powering the board up.
   task automatic test_wake();
      for (int k = 0; k < 4; k++) begin
         wake(k, 1'b0, seen);
         `CHK(seen, 1'b0)
         `CHK(psu_on_oe_n_o, 1'b1)
         `CHK(led_rgb_o, COL_YELLOW)
         wake(k, 1'b1, seen);
         `CHK(seen, 1'b1)
         `CHK({psu_on_oe_n_o, psu_on_n_o}, 2'b00)
         @(posedge sys_clk_i);
         supply_ok_i <= 4'h7;
         settle(8);
         `CHK(power_good_o, 1'b0)
         @(posedge sys_clk_i);
         supply_ok_i <= 4'hF;
         seen = 1'b0;
         for (int i = 0; i < 12; i++) begin
            settle(1);
            if (power_good_o === 1'b1) seen = 1'b1;
         end
         `CHK(seen, 1'b1)
         `CHK(led_rgb_o, COL_GREEN)
         if (k < 3) begin
            @(posedge sys_clk_i);
            sleep_req_i <= 1'b1;
            settle(6);
            `CHK({power_good_o, psu_on_oe_n_o}, 2'b01)
            @(posedge sys_clk_i);
            sleep_req_i <= 1'b0;
            supply_ok_i <= 4'h0;
            settle(6);
         end
      end
   endtask

   // Manual codes, upper bits kept as plain storage, enable and automatic return.
   task automatic test_led();
      for (logic [7:0] c = 8'h08; c <= 8'h0F; c++) begin
         io_wr(LED_CTRL_ADDR, 8'hA0 | c);
         settle(2);
         `CHK(led_rgb_o, c[2:0])
         io_rd(LED_CTRL_ADDR, rd);
         `CHK(rd, 8'hA0 | c)
      end
      io_wr(16'h0455, 8'h00);
      io_rd(LED_CTRL_ADDR, rd);
      `CHK(rd, 8'hAF)
      io_rd(16'h0458, rd);
      `CHK(rd, 8'h00)
      io_wr(LED_CTRL_ADDR, 8'hFF);
      io_rd(LED_CTRL_ADDR, rd);
      `CHK(rd, 8'hEF)
      @(posedge sys_clk_i);
      cfg_led_en_i <= 1'b0;
      settle(3);
      `CHK(led_rgb_o, COL_OFF)
      @(posedge sys_clk_i);
      cfg_led_en_i <= 1'b1;
      io_wr(LED_CTRL_ADDR, 8'hE0);
      settle(3);
      `CHK(led_rgb_o, COL_GREEN)
      led_case(5'b01100, COL_WHITE);
      led_case(5'b00110, COL_BLUE);
      led_case(5'b00011, COL_MAGENTA);
      led_case(5'b00010, COL_CYAN);
      led_case(5'b11000, COL_RED);
      led_case(5'b00000, COL_GREEN);
      // Activity must show both the lit and the dark half of the blink.
      @(posedge sys_clk_i);
      eth_link_i <= 1'b1;
      eth_act_i <= 1'b1;
      settle(6);
      rd = 8'h00;
      for (int i = 0; i < 24; i++) begin
         settle(1);
         if (led_rgb_o === COL_OFF) rd[0] = 1'b1;
         if (led_rgb_o === COL_CYAN) rd[1] = 1'b1;
      end
      `CHK(rd, 8'h03)
   endtask

   // Jumper fitted at power-up forces red, held after it is removed.
   task automatic test_jumper();
      @(posedge sys_clk_i);
      default_config_jumper_i <= 1'b1;
      sys_rst_i <= 1'b1;
      settle(8);
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      settle(8);
      `CHK(led_rgb_o, COL_RED)
      @(posedge sys_clk_i);
      default_config_jumper_i <= 1'b0;
      settle(8);
      `CHK(led_rgb_o, COL_RED)
   endtask

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Main sequence.
   initial begin
      settle(7);
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      settle(2);
      io_rd(LED_CTRL_ADDR, rd);
      `CHK(rd, LED_CTRL_RESET)
      io_rd(RST_CAUSE_ADDR, rd);
      `CHK(rd, RST_CAUSE_RESET)
      test_cause();
      test_wake();
      test_led();
      test_jumper();
      test_done();
   end

   // Guards against a hang anywhere in the sequence.
   initial begin
      #2000000;
      err_count++;
      test_done();
   end
endmodule
`default_nettype wire
